// file: verilog/pmc_mode_ctrl.sv
// Operating-mode controller: mode sequencing, supervision, indicators and load figures.
// Notes on behaviour
// - Always exactly one of stopped, starting up, running or held.
// - Stopped: no program execution, output inhibit active.
// - Entering stop keeps counters, timers, flags and process image.
// - Stop to run calls the start-up handler, unsupervised in time.
// - Output inhibit stays active throughout start-up.
// - Run indicator blinks at least 3 s from start-up begin, whatever follows; the code skips it if start-up stops or ends within its first two cycles.
// - Completed start-up handler moves the mode to running.
// - Clear input image, start-up handler, then release inhibit and clear outputs together, cycle.
// - Running cycle: read input image, main handler, write output image.
// - Running keeps program timers active and refreshes the image each cycle.
// - Running releases inhibit, run indicator on, stop indicator off.
// - Up to three breakpoints; reaching an active one enters hold.
// - Single step is refused when more than two breakpoints are defined.
// - Held: no code executes and program timers freeze.
// - Held: the real-time clock keeps advancing.
// - Held: inhibit active, links kept, run blinks, stop indicator on.
// - 100 ms watchdog and cycle supervisor (min 1 ms) force a defined stop.
// - Leaving run drives analog outputs to safe or substitute values.
// - Overall reset erases user memory; network address survives until power-on.
// - Load measured every 100 ms: last, average of ten, minimum, maximum.
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned BLINK_MIN_CYC = `PMC_BLINK_MIN_CYC,
  parameter int unsigned WATCHDOG_CYC = `PMC_WATCHDOG_CYC,
  parameter int unsigned LOAD_WINDOW_CYC = `PMC_LOAD_WINDOW_CYC,
  parameter int unsigned LOAD_PCT_CYC = `PMC_LOAD_PCT_CYC,
  parameter int unsigned BLINK_HALF_CYC = `PMC_BLINK_HALF_CYC,
  parameter int unsigned CYC_PER_MS = `PMC_CYC_PER_MS,
  parameter int unsigned USER_MEM_WORDS = `PMC_USER_MEM_WORDS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Mode requests and configuration.
  input wire logic run_request,
  input wire logic stop_request,
  input wire logic [7:0] cycle_limit_ms,
  input wire logic substitute_cfg,
  // Handler execution feedback.
  input wire logic startup_done,
  input wire logic startup_error,
  input wire logic main_done,
  input wire logic watchdog_kick,
  input wire logic cpu_busy,
  // Breakpoints.
  input wire logic [2:0] bp_defined,
  input wire logic [2:0] bp_active,
  input wire logic [2:0] bp_reached,
  input wire logic resume_cmd,
  input wire logic step_cmd,
  // Overall reset and network address.
  input wire logic overall_reset_req,
  input wire logic net_addr_load,
  input wire logic [31:0] net_addr_in,
  // Mode and sequencing outputs.
  output pmc_mode_t mode,
  output logic clear_input_image,
  output logic exec_startup,
  output logic clear_output_image,
  output logic read_input_image,
  output logic exec_main,
  output logic write_output_image,
  output logic program_timer_enable,
  output logic rtc_tick,
  output logic step_refused,
  // Outputs toward the I/O modules and indicators.
  output logic output_inhibit,
  output logic analog_safe,
  output logic analog_substitute,
  output logic run_indicator,
  output logic stop_indicator,
  // Supervision faults.
  output logic watchdog_fault,
  output logic cycle_fault,
  // User memory erase.
  output logic erase_we,
  output logic [15:0] erase_addr,
  output logic erase_busy,
  output logic [31:0] net_addr,
  // Load figures in percent.
  output logic [6:0] load_last,
  output logic [6:0] load_avg,
  output logic [6:0] load_min,
  output logic [6:0] load_max
);
  function automatic logic [1:0] bp_count(input logic [2:0] bits);
    bp_count = {1'b0, bits[0]} + {1'b0, bits[1]} + {1'b0, bits[2]};
  endfunction : bp_count

  pmc_mode_t mode_reg, mode_next;
  pmc_phase_t phase_reg, phase_next;
  logic fault_now;
  logic step_ok;
  logic [31:0] blink_min_reg;
  logic [31:0] blink_div_reg;
  logic blink_reg;
  logic [31:0] ms_div_reg;
  logic ms_tick;
  logic [31:0] wd_cnt_reg;
  logic [7:0] cyc_ms_reg;
  logic [7:0] limit_ms;
  logic [31:0] win_cnt_reg;
  logic [31:0] pct_sub_reg;
  logic [6:0] pct_reg;
  logic win_end;
  logic [3:0] hist_ptr_reg;
  logic [3:0] hist_fill_reg;
  logic [6:0] hist_old;
  logic [9:0] hist_sum_reg;
  logic [9:0] sum_next;
  logic [3:0] fill_next;
  logic first_sample_reg;

  assign step_ok = bp_count(bp_defined) <= 2'(`PMC_STEP_MAX_BP);
  assign step_refused = (mode_reg == PMC_MODE_HOLD) && step_cmd && !step_ok;
  assign limit_ms = (cycle_limit_ms < `PMC_CYCLE_LIMIT_MIN_MS) ? `PMC_CYCLE_LIMIT_MIN_MS :
                    cycle_limit_ms;
  // The watchdog only runs in running mode, so a long start-up handler never trips it.
  assign fault_now = (mode_reg == PMC_MODE_RUN) &&
                     ((wd_cnt_reg >= WATCHDOG_CYC - 1) || (cyc_ms_reg >= limit_ms));

  always_comb begin
    mode_next = mode_reg;
    phase_next = phase_reg;
    case (mode_reg)
      PMC_MODE_STOP: begin
        phase_next = PMC_PH_IDLE;
        if (run_request && !stop_request && !erase_busy) begin
          mode_next = PMC_MODE_STARTUP;
          phase_next = PMC_PH_CLR_IN;
        end
      end
      PMC_MODE_STARTUP: begin
        if (stop_request) begin
          mode_next = PMC_MODE_STOP;
          phase_next = PMC_PH_IDLE;
        end else if (phase_reg == PMC_PH_CLR_IN) begin
          phase_next = PMC_PH_STARTUP;
        end else if (startup_error) begin
          mode_next = PMC_MODE_STOP;
          phase_next = PMC_PH_IDLE;
        end else if (startup_done) begin
          mode_next = PMC_MODE_RUN;
          phase_next = PMC_PH_CLR_OUT;
        end
      end
      PMC_MODE_RUN: begin
        if (stop_request || fault_now) begin
          mode_next = PMC_MODE_STOP;
          phase_next = PMC_PH_IDLE;
        end else if (phase_reg == PMC_PH_MAIN && (bp_reached & bp_active) != 3'h0) begin
          mode_next = PMC_MODE_HOLD;
        end else begin
          case (phase_reg)
            PMC_PH_CLR_OUT: phase_next = PMC_PH_READ_IN;
            PMC_PH_READ_IN: phase_next = PMC_PH_MAIN;
            PMC_PH_MAIN: phase_next = main_done ? PMC_PH_WRITE_OUT : PMC_PH_MAIN;
            PMC_PH_WRITE_OUT: phase_next = PMC_PH_READ_IN;
            default: phase_next = PMC_PH_READ_IN;
          endcase
        end
      end
      PMC_MODE_HOLD: begin
        if (stop_request) begin
          mode_next = PMC_MODE_STOP;
          phase_next = PMC_PH_IDLE;
        end else if (resume_cmd || (step_cmd && step_ok)) begin
          mode_next = PMC_MODE_RUN;
        end
      end
      default: begin
        mode_next = PMC_MODE_STOP;
        phase_next = PMC_PH_IDLE;
      end
    endcase
  end

  // Entering stop clears nothing, so images and program state stay as they were.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= PMC_MODE_STOP;
      phase_reg <= PMC_PH_IDLE;
    end else begin
      mode_reg <= mode_next;
      phase_reg <= phase_next;
    end
  end

  assign mode = mode_reg;
  assign clear_input_image = (phase_reg == PMC_PH_CLR_IN);
  assign exec_startup = (mode_reg == PMC_MODE_STARTUP) && (phase_reg == PMC_PH_STARTUP);
  assign clear_output_image = (mode_reg == PMC_MODE_RUN) && (phase_reg == PMC_PH_CLR_OUT);
  assign read_input_image = (mode_reg == PMC_MODE_RUN) && (phase_reg == PMC_PH_READ_IN);
  assign exec_main = (mode_reg == PMC_MODE_RUN) && (phase_reg == PMC_PH_MAIN);
  assign write_output_image = (mode_reg == PMC_MODE_RUN) && (phase_reg == PMC_PH_WRITE_OUT);
  assign program_timer_enable = (mode_reg == PMC_MODE_RUN);

  // Inhibit is lifted only in running mode; configured links are not touched in hold.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      output_inhibit <= 1'b1;
      analog_safe <= 1'b1;
      analog_substitute <= 1'b0;
    end else begin
      output_inhibit <= (mode_next != PMC_MODE_RUN);
      analog_safe <= (mode_next != PMC_MODE_RUN);
      analog_substitute <= (mode_next != PMC_MODE_RUN) && substitute_cfg;
    end
  end

  // Free-running millisecond tick; it never stops, so the real-time clock advances in hold.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ms_div_reg <= 32'h0;
    end else if (ms_div_reg >= CYC_PER_MS - 1) begin
      ms_div_reg <= 32'h0;
    end else begin
      ms_div_reg <= ms_div_reg + 32'h1;
    end
  end
  assign ms_tick = (ms_div_reg >= CYC_PER_MS - 1);
  assign rtc_tick = ms_tick;

  // Watchdog and cycle-time supervision; while held the watchdog count is cleared and the cycle time freezes.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt_reg <= 32'h0;
    end else if (mode_reg != PMC_MODE_RUN || watchdog_kick) begin
      wd_cnt_reg <= 32'h0;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cyc_ms_reg <= 8'h00;
    end else if (mode_reg != PMC_MODE_RUN && mode_reg != PMC_MODE_HOLD) begin
      cyc_ms_reg <= 8'h00;
    end else if (read_input_image) begin
      cyc_ms_reg <= 8'h00;
    end else if (mode_reg == PMC_MODE_RUN && ms_tick && cyc_ms_reg != 8'hff) begin
      cyc_ms_reg <= cyc_ms_reg + 8'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_fault <= 1'b0;
      cycle_fault <= 1'b0;
    end else begin
      if (fault_now && wd_cnt_reg >= WATCHDOG_CYC - 1) begin
        watchdog_fault <= 1'b1;
      end else if (mode_reg == PMC_MODE_STOP && run_request) begin
        watchdog_fault <= 1'b0;
      end
      if (fault_now && cyc_ms_reg >= limit_ms) begin
        cycle_fault <= 1'b1;
      end else if (mode_reg == PMC_MODE_STOP && run_request) begin
        cycle_fault <= 1'b0;
      end
    end
  end

  // Indicators: the minimum blink time runs on after a stop or finish that comes later than the first start-up handler cycle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      blink_min_reg <= 32'h0;
    end else if (exec_startup && phase_reg != PMC_PH_IDLE && blink_min_reg == 32'h0 &&
                 mode_reg == PMC_MODE_STARTUP && phase_next == PMC_PH_STARTUP) begin
      blink_min_reg <= BLINK_MIN_CYC;
    end else if (blink_min_reg != 32'h0) begin
      blink_min_reg <= blink_min_reg - 32'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      blink_div_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (blink_div_reg >= BLINK_HALF_CYC - 1) begin
      blink_div_reg <= 32'h0;
      blink_reg <= !blink_reg;
    end else begin
      blink_div_reg <= blink_div_reg + 32'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_indicator <= 1'b0;
      stop_indicator <= 1'b1;
    end else begin
      if (blink_min_reg > 32'h1 || mode_reg == PMC_MODE_STARTUP ||
          mode_reg == PMC_MODE_HOLD) begin
        run_indicator <= blink_reg;
      end else begin
        run_indicator <= (mode_reg == PMC_MODE_RUN);
      end
      stop_indicator <= (mode_reg == PMC_MODE_STOP) || (mode_reg == PMC_MODE_HOLD);
    end
  end

  // Overall reset sweeps user memory; the network address register is left alone.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      erase_busy <= 1'b0;
      erase_addr <= 16'h0000;
    end else if (!erase_busy) begin
      erase_addr <= 16'h0000;
      if (overall_reset_req && mode_reg == PMC_MODE_STOP) begin
        erase_busy <= 1'b1;
      end
    end else if ({16'h0000, erase_addr} >= USER_MEM_WORDS - 1) begin
      erase_busy <= 1'b0;
      erase_addr <= 16'h0000;
    end else begin
      erase_addr <= erase_addr + 16'h0001;
    end
  end
  assign erase_we = erase_busy;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      net_addr <= 32'h0;
    end else if (net_addr_load) begin
      net_addr <= net_addr_in;
    end
  end

  // Load: every LOAD_PCT_CYC busy cycles within a window count one percent.
  assign win_end = (win_cnt_reg >= LOAD_WINDOW_CYC - 1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt_reg <= 32'h0;
      pct_sub_reg <= 32'h0;
      pct_reg <= 7'h00;
    end else if (win_end) begin
      win_cnt_reg <= 32'h0;
      pct_sub_reg <= 32'h0;
      pct_reg <= 7'h00;
    end else begin
      win_cnt_reg <= win_cnt_reg + 32'h1;
      if (cpu_busy) begin
        if (pct_sub_reg >= LOAD_PCT_CYC - 1) begin
          pct_sub_reg <= 32'h0;
          if (pct_reg < `PMC_LOAD_FULL) begin
            pct_reg <= pct_reg + 7'h01;
          end
        end else begin
          pct_sub_reg <= pct_sub_reg + 32'h1;
        end
      end
    end
  end

  pmc_load_hist u_hist (
    .clock(clock),
    .wr_en(win_end),
    .wr_addr(hist_ptr_reg),
    .wr_data(pct_reg),
    .rd_addr(hist_ptr_reg),
    .rd_data(hist_old)
  );

  // The oldest sample is read back before it is overwritten, so the sum stays exact.
  assign sum_next = hist_sum_reg + {3'h0, pct_reg} -
                    ((hist_fill_reg == 4'(`PMC_LOAD_HIST)) ? {3'h0, hist_old} : 10'h000);
  assign fill_next = (hist_fill_reg == 4'(`PMC_LOAD_HIST)) ? hist_fill_reg :
                     hist_fill_reg + 4'h1;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hist_ptr_reg <= 4'h0;
      hist_fill_reg <= 4'h0;
      hist_sum_reg <= 10'h000;
      first_sample_reg <= 1'b1;
      load_last <= 7'h00;
      load_avg <= 7'h00;
      load_min <= 7'h00;
      load_max <= 7'h00;
    end else if (win_end) begin
      hist_ptr_reg <= (hist_ptr_reg == 4'(`PMC_LOAD_HIST - 1)) ? 4'h0 : hist_ptr_reg + 4'h1;
      hist_fill_reg <= fill_next;
      hist_sum_reg <= sum_next;
      first_sample_reg <= 1'b0;
      load_last <= pct_reg;
      load_avg <= 7'(sum_next / {6'h00, fill_next});
      if (first_sample_reg || pct_reg < load_min) begin
        load_min <= pct_reg;
      end
      if (first_sample_reg || pct_reg > load_max) begin
        load_max <= pct_reg;
      end
    end
  end
endmodule : pmc_mode_ctrl

// file: verilog/pmc_regs.svh
// Timing counts and fixed sizes of the operating-mode controller.
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_CLK_HZ 20000000
`define PMC_CYC_PER_MS (`PMC_CLK_HZ / 1000)
`define PMC_BLINK_MIN_MS 3000
`define PMC_BLINK_MIN_CYC (`PMC_BLINK_MIN_MS * `PMC_CYC_PER_MS)
`define PMC_WATCHDOG_MS 100
`define PMC_WATCHDOG_CYC (`PMC_WATCHDOG_MS * `PMC_CYC_PER_MS)
`define PMC_LOAD_WINDOW_MS 100
`define PMC_LOAD_WINDOW_CYC (`PMC_LOAD_WINDOW_MS * `PMC_CYC_PER_MS)
`define PMC_LOAD_PCT_CYC (`PMC_LOAD_WINDOW_CYC / 100)
`define PMC_BLINK_HALF_MS 250
`define PMC_BLINK_HALF_CYC (`PMC_BLINK_HALF_MS * `PMC_CYC_PER_MS)
`define PMC_CYCLE_LIMIT_MIN_MS 8'h01
`define PMC_USER_MEM_WORDS 65536
`define PMC_BREAKPOINTS 3
`define PMC_STEP_MAX_BP 2
`define PMC_LOAD_HIST 10
`define PMC_LOAD_FULL 7'h64
`endif

// file: verilog/pmc_pkg.sv
// Types shared by the operating-mode controller.
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_MODE_STOP = 2'b00,
    PMC_MODE_STARTUP = 2'b01,
    PMC_MODE_RUN = 2'b10,
    PMC_MODE_HOLD = 2'b11
  } pmc_mode_t;
  typedef enum logic [2:0] {
    PMC_PH_IDLE = 3'b000,
    PMC_PH_CLR_IN = 3'b001,
    PMC_PH_STARTUP = 3'b010,
    PMC_PH_CLR_OUT = 3'b011,
    PMC_PH_READ_IN = 3'b100,
    PMC_PH_MAIN = 3'b101,
    PMC_PH_WRITE_OUT = 3'b110
  } pmc_phase_t;
endpackage : pmc_pkg

// file: verilog/pmc_load_hist.sv
// Ten-entry history memory of load samples with registered read data.
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_load_hist (
  // Clock.
  input wire logic clock,
  // Write side.
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [6:0] wr_data,
  // Read side.
  input wire logic [3:0] rd_addr,
  output logic [6:0] rd_data
);
  logic [6:0] mem [0:`PMC_LOAD_HIST-1];
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule : pmc_load_hist

// file: verif/pmc_mode_ctrl_assertions.sv
// Checker of the operating-mode controller port behaviour.
`timescale 1ns/1ps
module pmc_mode_ctrl_chk
  import pmc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Requests and feedback.
  input wire logic run_request,
  input wire logic stop_request,
  input wire logic startup_done,
  input wire logic startup_error,
  input wire logic main_done,
  input wire logic [2:0] bp_defined,
  input wire logic [2:0] bp_active,
  input wire logic [2:0] bp_reached,
  input wire logic resume_cmd,
  input wire logic step_cmd,
  input wire logic overall_reset_req,
  // Observed outputs.
  input pmc_mode_t mode,
  input wire logic clear_input_image,
  input wire logic exec_startup,
  input wire logic clear_output_image,
  input wire logic read_input_image,
  input wire logic exec_main,
  input wire logic write_output_image,
  input wire logic program_timer_enable,
  input wire logic step_refused,
  input wire logic output_inhibit,
  input wire logic analog_safe,
  input wire logic stop_indicator,
  input wire logic erase_busy,
  input wire logic [15:0] erase_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire bp_hit = (bp_reached & bp_active) != 3'b000;
  sequence s_startup_entry;
    clear_input_image && mode == PMC_MODE_STARTUP ##1 exec_startup;
  endsequence
  sequence s_run_entry;
    mode == PMC_MODE_RUN && clear_output_image && !output_inhibit ##1 read_input_image;
  endsequence
  sequence s_cycle_tail;
    write_output_image ##1 read_input_image;
  endsequence
  property p_inhibit;
    output_inhibit == (mode != PMC_MODE_RUN) && analog_safe == output_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit does not follow mode");
  property p_stop_idle;
    mode == PMC_MODE_STOP |-> !exec_main && !exec_startup;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("handler runs while stopped");
  property p_stop_wins;
    stop_request |=> mode == PMC_MODE_STOP;
  endproperty
  a_stop_wins: assert property (p_stop_wins)
    else $error("stop request not obeyed");
  property p_startup_entry;
    mode == PMC_MODE_STOP && run_request && !stop_request && !erase_busy |=> s_startup_entry;
  endproperty
  a_startup_entry: assert property (p_startup_entry)
    else $error("start-up entry order wrong");
  property p_run_entry;
    exec_startup && startup_done && !startup_error && !stop_request |=> s_run_entry;
  endproperty
  a_run_entry: assert property (p_run_entry)
    else $error("run entry order wrong");
  property p_cycle;
    mode == PMC_MODE_RUN && exec_main && main_done && !stop_request && !bp_hit
      |=> (mode != PMC_MODE_RUN) or s_cycle_tail;
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("cycle order wrong");
  property p_hold_entry;
    mode == PMC_MODE_RUN && exec_main && bp_hit && !stop_request
      |=> mode == PMC_MODE_HOLD && !exec_main;
  endproperty
  a_hold_entry: assert property (p_hold_entry)
    else $error("breakpoint did not hold");
  property p_step_refuse;
    step_refused == (mode == PMC_MODE_HOLD && step_cmd && bp_defined == 3'b111);
  endproperty
  a_step_refuse: assert property (p_step_refuse)
    else $error("step refusal wrong");
  property p_resume;
    mode == PMC_MODE_HOLD && resume_cmd && !stop_request |=> mode == PMC_MODE_RUN && !output_inhibit;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not run");
  property p_timers;
    program_timer_enable == (mode == PMC_MODE_RUN);
  endproperty
  a_timers: assert property (p_timers)
    else $error("program timers wrong");
  property p_stop_indicator;
    stop_indicator == $past(mode == PMC_MODE_STOP || mode == PMC_MODE_HOLD);
  endproperty
  a_stop_indicator: assert property (p_stop_indicator)
    else $error("stop indicator wrong");
  property p_erase;
    mode == PMC_MODE_STOP && overall_reset_req && !erase_busy |=> erase_busy && erase_addr == 16'h0000;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase did not start");
endmodule : pmc_mode_ctrl_chk

bind pmc_mode_ctrl pmc_mode_ctrl_chk u_chk (.*);

// file: verif/pmc_exec_model.sv
// Behavioural model of the program execution answering the handler strobes.
`timescale 1ns/1ps
module pmc_exec_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Handler strobes and scenario controls.
  input wire logic exec_startup,
  input wire logic exec_main,
  input wire logic slow,
  input wire logic fail,
  input wire logic kick_en,
  // Feedback to the controller.
  output logic startup_done,
  output logic startup_error,
  output logic main_done,
  output logic watchdog_kick
);
  logic [5:0] cnt;
  logic done;
  // A count left over from an aborted handler only makes the next answer early.
  always @(negedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 6'h00;
      done <= 1'b0;
    end else if (done) begin
      cnt <= 6'h00;
      done <= 1'b0;
    end else if (exec_startup || exec_main) begin
      cnt <= cnt + 6'h01;
      done <= cnt >= (slow ? 6'h1e : 6'h02);
    end
  end
  assign startup_done = done && exec_startup && !fail;
  assign startup_error = done && exec_startup && fail;
  assign main_done = done && exec_main;
  assign watchdog_kick = main_done && kick_en;
endmodule : pmc_exec_model

// file: verif/tb_top.sv
// Self-checking bench of the operating-mode controller.
`timescale 1ns/1ps
module tb_top;
  import pmc_pkg::*;
  logic clock, rst_b, run_request, stop_request, substitute_cfg, cpu_busy, watchdog_kick;
  logic startup_done, startup_error, main_done, resume_cmd, step_cmd, overall_reset_req;
  logic net_addr_load, slow, fail, kick_en;
  logic [7:0] cycle_limit_ms;
  logic [2:0] bp_defined, bp_active, bp_reached;
  logic [31:0] net_addr_in, net_addr;
  pmc_mode_t mode;
  logic clear_input_image, exec_startup, clear_output_image, read_input_image, exec_main;
  logic write_output_image, program_timer_enable, rtc_tick, step_refused, output_inhibit;
  logic analog_safe, analog_substitute, run_indicator, stop_indicator, watchdog_fault;
  logic cycle_fault, erase_we, erase_busy;
  logic [15:0] erase_addr;
  logic [6:0] load_last, load_avg, load_min, load_max;
  int err_count, total_checks;
  pmc_mode_ctrl #(.BLINK_MIN_CYC(300), .WATCHDOG_CYC(200), .LOAD_WINDOW_CYC(1000),
    .LOAD_PCT_CYC(10), .BLINK_HALF_CYC(20), .CYC_PER_MS(20), .USER_MEM_WORDS(16)) u_dut (.*);
  pmc_exec_model u_exec (.clock, .rst_b, .exec_startup, .exec_main, .slow, .fail, .kick_en,
    .startup_done, .startup_error, .main_done, .watchdog_kick);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic stop_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic pulse_run;
    run_request = 1'b1;
    cyc(1);
    run_request = 1'b0;
  endtask : pulse_run
  task automatic wait_mode(input pmc_mode_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) begin
      cyc(1);
    end
  endtask : wait_mode
  task automatic hit_bp;
    for (int i = 0; i < 40 && read_input_image !== 1'b1; i++) begin
      cyc(1);
    end
    for (int i = 0; i < 40 && exec_main !== 1'b1; i++) begin
      cyc(1);
    end
    bp_reached = 3'b010;
    cyc(1);
    bp_reached = 3'b000;
  endtask : hit_bp
  task automatic t_erase;
    int n;
    logic [15:0] last;
    net_addr_in = 32'h5a5a1234;
    net_addr_load = 1'b1;
    cyc(1);
    net_addr_load = 1'b0;
    overall_reset_req = 1'b1;
    cyc(1);
    overall_reset_req = 1'b0;
    run_request = 1'b1;
    n = 0;
    while (erase_busy === 1'b1 && erase_we === 1'b1 && n < 40) begin
      last = erase_addr;
      n++;
      cyc(1);
    end
    run_request = 1'b0;
    check(n, 16);
    check(last, 16'h000f);
    check(mode, PMC_MODE_STOP);
    check(net_addr, 32'h5a5a1234);
    stop_request = 1'b1;
    pulse_run();
    stop_request = 1'b0;
    check(mode, PMC_MODE_STOP);
  endtask : t_erase
  task automatic t_start_err;
    logic seen;
    fail = 1'b1;
    pulse_run();
    wait_mode(PMC_MODE_STOP, 40);
    fail = 1'b0;
    check(mode, PMC_MODE_STOP);
    seen = 1'b0;
    repeat (100) begin
      seen |= (run_indicator === 1'b1);
      cyc(1);
    end
    check(seen, 1'b1);
    cyc(300);
    check(run_indicator, 1'b0);
  endtask : t_start_err
  task automatic t_start_run;
    logic seen;
    pulse_run();
    check(mode, PMC_MODE_STARTUP);
    check(clear_input_image, 1'b1);
    cyc(1);
    check(exec_startup, 1'b1);
    check(output_inhibit, 1'b1);
    wait_mode(PMC_MODE_RUN, 20);
    check(clear_output_image, 1'b1);
    check(output_inhibit, 1'b0);
    cyc(1);
    check(read_input_image, 1'b1);
    cyc(220);
    seen = 1'b0;
    repeat (60) begin
      seen |= (run_indicator === 1'b0);
      cyc(1);
    end
    check(seen, 1'b1);
    cyc(100);
    check(run_indicator, 1'b1);
    check(stop_indicator, 1'b0);
    check(watchdog_fault | cycle_fault, 1'b0);
  endtask : t_start_run
  task automatic t_hold;
    int n;
    bp_active = 3'b010;
    hit_bp();
    check(mode, PMC_MODE_HOLD);
    check(output_inhibit, 1'b1);
    check(program_timer_enable, 1'b0);
    n = 0;
    repeat (200) begin
      n += (rtc_tick === 1'b1);
      cyc(1);
    end
    check(n, 10);
    check(stop_indicator, 1'b1);
    check(mode, PMC_MODE_HOLD);
    check(exec_main, 1'b0);
    bp_defined = 3'b111;
    step_cmd = 1'b1;
    #1 check(step_refused, 1'b1);
    cyc(1);
    step_cmd = 1'b0;
    check(mode, PMC_MODE_HOLD);
    bp_defined = 3'b011;
    step_cmd = 1'b1;
    cyc(1);
    step_cmd = 1'b0;
    check(mode, PMC_MODE_RUN);
    hit_bp();
    check(mode, PMC_MODE_HOLD);
    resume_cmd = 1'b1;
    cyc(1);
    resume_cmd = 1'b0;
    check(mode, PMC_MODE_RUN);
    check(output_inhibit, 1'b0);
    bp_active = 3'b000;
  endtask : t_hold
  task automatic t_faults;
    int n;
    slow = 1'b1;
    cycle_limit_ms = 8'h01;
    wait_mode(PMC_MODE_STOP, 200);
    slow = 1'b0;
    cycle_limit_ms = 8'h0a;
    check(cycle_fault, 1'b1);
    check(watchdog_fault, 1'b0);
    check(analog_safe, 1'b1);
    check(analog_substitute, 1'b1);
    substitute_cfg = 1'b0;
    pulse_run();
    wait_mode(PMC_MODE_RUN, 40);
    check(cycle_fault, 1'b0);
    kick_en = 1'b0;
    n = 0;
    while (mode === PMC_MODE_RUN && n < 400) begin
      n++;
      cyc(1);
    end
    kick_en = 1'b1;
    check(n >= 185 && n <= 201, 1'b1);
    check(watchdog_fault, 1'b1);
    check(analog_substitute, 1'b0);
  endtask : t_faults
  task automatic t_load;
    cpu_busy = 1'b1;
    cyc(2500);
    check(load_last, 7'h63);
    check(load_max, 7'h63);
    check(load_avg > 7'h00 && load_avg < 7'h64, 1'b1);
    cpu_busy = 1'b0;
    cyc(2100);
    check(load_last, 7'h00);
    check(load_min, 7'h00);
  endtask : t_load
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    stop_test();
  end
  initial begin
    {rst_b, run_request, stop_request, cpu_busy, resume_cmd, step_cmd} = 6'h00;
    {overall_reset_req, net_addr_load, slow, fail} = 4'h0;
    {bp_defined, bp_active, bp_reached} = 9'h000;
    kick_en = 1'b1;
    substitute_cfg = 1'b1;
    cycle_limit_ms = 8'h0a;
    net_addr_in = 32'h00000000;
    cyc(10);
    rst_b = 1'b1;
    check(mode, PMC_MODE_STOP);
    check(output_inhibit & stop_indicator & ~run_indicator, 1'b1);
    check(net_addr, 32'h00000000);
    t_erase();
    t_start_err();
    t_start_run();
    t_hold();
    t_faults();
    t_load();
    stop_test();
  end
endmodule : tb_top
